// >>> hdl/i2ccr_map.vh
// Purpose: register map, fields, resets and timing counts
// Assumes: 32-bit register words at byte offsets, clk at 50 MHz
// Notes: definitions only
`ifndef I2CCR_MAP_VH
`define I2CCR_MAP_VH

// Register offsets
`define I2CCR_AW 6
`define I2CCR_OFF_CTRL 6'h00
`define I2CCR_OFF_STAT 6'h04
`define I2CCR_OFF_IRQ 6'h08
`define I2CCR_OFF_MASK 6'h0c
`define I2CCR_OFF_RXB 6'h10
`define I2CCR_OFF_SADDR 6'h14

// Control word fields
`define I2CCR_B_START_SEQ 0
`define I2CCR_B_RSTART 1
`define I2CCR_B_STOP_SEQ 2
`define I2CCR_B_RECV 3
`define I2CCR_B_ACK_SEQ 4
`define I2CCR_B_ACK_DATA 5
`define I2CCR_B_GCALL 7
`define I2CCR_B_CLK_REL 12
`define I2CCR_B_STOP_IDLE 13
`define I2CCR_B_ENABLE 15
`define I2CCR_B_DATA_HOLD 16
`define I2CCR_B_ADDR_HOLD 17
`define I2CCR_B_SLV_COLL 18
`define I2CCR_B_HOLD_TIME 19
`define I2CCR_B_BUF_OVW 20
`define I2CCR_B_START_IRQ 21
`define I2CCR_B_STOP_IRQ 22
`define I2CCR_CTRL_RST 32'h0000_1000
`define I2CCR_CTRL_WMASK 32'h007f_bfff

// Status word fields
`define I2CCR_S_BUSY 0
`define I2CCR_S_FULL 2
`define I2CCR_S_OVERFLOW 6

// Interrupt status and mask fields
`define I2CCR_I_START 0
`define I2CCR_I_STOP 1
`define I2CCR_I_COLL 2
`define I2CCR_I_MDONE 3
`define I2CCR_I_SBYTE 4
`define I2CCR_IRQ_W 5

// Reset values
`define I2CCR_SADDR_RST 7'h2a
`define I2CCR_HALF_PERIOD 8'd125

// Timing
`define I2CCR_CLK_NS 20
`define I2CCR_HOLD_LONG_NS 300
`define I2CCR_HOLD_SHORT_NS 100
`define I2CCR_HOLD_LONG_CYC ((`I2CCR_HOLD_LONG_NS + `I2CCR_CLK_NS - 1) / `I2CCR_CLK_NS)
`define I2CCR_HOLD_SHORT_CYC ((`I2CCR_HOLD_SHORT_NS + `I2CCR_CLK_NS - 1) / `I2CCR_CLK_NS)

`endif

// >>> hdl/i2ccr_sync.v
// Purpose: two-flop synchroniser with edge detection for one bus pin
// Assumes: pin is asynchronous to clk; idles high
// Notes: edges are seen two to three cycles after the pin moves
`timescale 1ns/10ps
`default_nettype none
module i2ccr_sync (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // Pin side
  input wire pin_in,
  // Synchronised level and edges
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg prev_q;

  // Only level_q reads meta_q, so nothing sees a metastable value
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (ce) begin
      meta_q <= pin_in;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  // One-cycle edge pulses
  assign rise = ce & level_q & ~prev_q;
  assign fall = ce & ~level_q & prev_q;
endmodule // i2ccr_sync
`default_nettype wire

// >>> hdl/i2ccr_tick.v
// Purpose: half-period tick generator for the master sequencer
// Assumes: HALF at least 2
// Notes: restarts from zero whenever run drops
`timescale 1ns/10ps
`default_nettype none
module i2ccr_tick #(
  parameter W = 8,
  parameter [W-1:0] HALF = 8'd125
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // Control
  input wire run,
  // One-cycle tick every HALF cycles
  output wire tick
);
  localparam [W-1:0] LAST = HALF - 1'b1;
  reg [W-1:0] cnt_q;

  // Counts while running, else parked at zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= {W{1'b0}};
    end else if (ce) begin
      if (!run || cnt_q == LAST) begin
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign tick = ce & run & (cnt_q == LAST);
endmodule // i2ccr_tick
`default_nettype wire

// >>> hdl/i2ccr_top.v
// Purpose: serial bus control register with master sequencer and receive-only slave
// Assumes: open-drain pins sampled on clk; plain strobe register port
// Notes on behaviour
// [R1] Slave stop seen raises an interrupt only while stop irq enable is set.
// [R2] Slave start or repeated start raises an interrupt only while start irq enable set.
// [R3] Overwrite enabled: byte taken and acked despite overflow, if buffer not full.
// [R4] Hold time select keeps data stable 300 ns or 100 ns after clock falls.
// [R5] Slave collision interrupts only while collision detect enable is set.
// [R6] Address hold: after matching address 8th fall, clear clock release, hold clock low.
// [R7] Data hold: after data byte 8th fall, clear clock release, hold clock low.
// [R8] Enable bit activates module and hands both pins to the serial port.
// [R9] Stop-in-idle bit halts the module while the device idles.
// [R10] Bits 31 to 23 and 14 are unimplemented and read zero.
// [R11] Clock release resets one, sequence bits reset zero and hardware clears them.
// [R12] Master sequence bits start their sequence and clear when it completes.
`timescale 1ns/10ps
`default_nettype none
`include "i2ccr_map.vh"
module i2ccr_top #(
  parameter [7:0] HALF_PERIOD = `I2CCR_HALF_PERIOD
) (
  // Clock, reset, enable
  input wire clk,
  input wire sys_rst,
  input wire ce,
  // Device idle indication
  input wire idle_mode,
  // Register port
  input wire [`I2CCR_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  // Clock pin
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  // Data pin
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Pin ownership and interrupt
  output wire pins_serial,
  output wire irq
);
  // Master states
  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_START = 3'h1;
  localparam [2:0] M_RSTART = 3'h2;
  localparam [2:0] M_STOP = 3'h3;
  localparam [2:0] M_RECV = 3'h4;
  localparam [2:0] M_ACK = 3'h5;
  // Slave states
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_BITS = 2'h1;
  localparam [1:0] S_ACK = 2'h2;
  localparam [1:0] S_SKIP = 2'h3;
  localparam integer HOLD_LONG = `I2CCR_HOLD_LONG_CYC;
  localparam integer HOLD_SHORT = `I2CCR_HOLD_SHORT_CYC;

  reg [31:0] ctrl_q;
  reg [7:0] rxbuf_q;
  reg full_q;
  reg ovf_q;
  reg [6:0] saddr_q;
  reg [`I2CCR_IRQ_W-1:0] irq_st_q;
  reg [`I2CCR_IRQ_W-1:0] irq_mask_q;
  reg [31:0] rdata_q;
  reg [2:0] m_state_q;
  reg [1:0] m_step_q;
  reg [3:0] m_bit_q;
  reg [7:0] m_shift_q;
  reg m_scl_q;
  reg m_sda_q;
  reg [1:0] s_state_q;
  reg [7:0] s_shift_q;
  reg [3:0] s_cnt_q;
  reg s_first_q;
  reg s_want_q;
  reg s_sda_q;
  reg [4:0] hold_cnt_q;
  reg scl_oe_q;
  reg sda_oe_q;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  wire m_tick;

  // Engine halts in idle with stop-in-idle set
  wire run = ce & ~(ctrl_q[`I2CCR_B_STOP_IDLE] & idle_mode); // [R9]
  wire on = ctrl_q[`I2CCR_B_ENABLE];
  wire m_idle = (m_state_q == M_IDLE);

  // Pin synchronisers
  i2ccr_sync u_scl_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(run),
    .pin_in(scl_in),
    .level_q(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  i2ccr_sync u_sda_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(run),
    .pin_in(sda_in),
    .level_q(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // Master bit timing
  i2ccr_tick #(
    .W(8),
    .HALF(HALF_PERIOD)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(run),
    .run(on & ~m_idle),
    .tick(m_tick)
  );

  // Bus conditions, seen only while master is idle
  wire start_det = sda_fall & scl_lvl & on & m_idle;
  wire stop_det = sda_rise & scl_lvl & on & m_idle;
  wire mid_byte = (s_state_q == S_BITS) & (s_cnt_q != 4'h0);
  wire coll_det = (start_det | stop_det) & mid_byte;

  // Slave byte completion and address match
  wire s_done = (s_state_q == S_BITS) & scl_fall & (s_cnt_q == 4'h8) & on & m_idle;
  wire s_gcall = ctrl_q[`I2CCR_B_GCALL] & (s_shift_q == 8'h00);
  wire s_addr_ok = ((s_shift_q[7:1] == saddr_q) & ~s_shift_q[0]) | s_gcall;
  wire s_take = s_done & (~s_first_q | s_addr_ok);
  // Overflow ignored only with overwrite on and buffer empty
  wire s_accept = s_take & ~full_q & (~ovf_q | ctrl_q[`I2CCR_B_BUF_OVW]); // [R3]
  wire s_hold_ev = s_take & (s_first_q ? ctrl_q[`I2CCR_B_ADDR_HOLD] : ctrl_q[`I2CCR_B_DATA_HOLD]);

  // Last tick of each master sequence
  wire m_last = m_tick & (((m_state_q == M_START) & (m_step_q == 2'h1)) |
                          ((m_state_q == M_RSTART) & (m_step_q == 2'h2)) |
                          ((m_state_q == M_STOP) & (m_step_q == 2'h1)) |
                          ((m_state_q == M_ACK) & (m_step_q == 2'h1)) |
                          ((m_state_q == M_RECV) & (m_step_q == 2'h1) & (m_bit_q == 4'h7)));
  wire m_rx_done = m_last & (m_state_q == M_RECV);
  wire [7:0] m_rx_byte = {m_shift_q[6:0], sda_lvl};

  // Bit owned by running sequence
  reg [31:0] m_clr;
  always @* begin
    m_clr = 32'h0000_0000;
    case (m_state_q)
      M_START: m_clr[`I2CCR_B_START_SEQ] = 1'b1;
      M_RSTART: m_clr[`I2CCR_B_RSTART] = 1'b1;
      M_STOP: m_clr[`I2CCR_B_STOP_SEQ] = 1'b1;
      M_RECV: m_clr[`I2CCR_B_RECV] = 1'b1;
      M_ACK: m_clr[`I2CCR_B_ACK_SEQ] = 1'b1;
      default: m_clr = 32'h0000_0000;
    endcase
  end

  wire wr_ctrl = reg_wr & (reg_addr == `I2CCR_OFF_CTRL);
  wire wr_stat = reg_wr & (reg_addr == `I2CCR_OFF_STAT);
  wire wr_irq = reg_wr & (reg_addr == `I2CCR_OFF_IRQ);
  wire rd_rxb = reg_rd & (reg_addr == `I2CCR_OFF_RXB);

  // Control word; hardware clears win over a write
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `I2CCR_CTRL_RST; // [R11]
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & `I2CCR_CTRL_WMASK; // [R10]
      end
      if (m_last) begin
        ctrl_q <= (wr_ctrl ? (reg_wdata & `I2CCR_CTRL_WMASK) : ctrl_q) & ~m_clr; // [R12] [R11]
      end
      if (s_hold_ev) begin
        ctrl_q[`I2CCR_B_CLK_REL] <= 1'b0; // [R6] [R7]
      end
    end
  end

  // Other software registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      saddr_q <= `I2CCR_SADDR_RST;
      irq_mask_q <= {`I2CCR_IRQ_W{1'b0}};
    end else if (ce && reg_wr) begin
      if (reg_addr == `I2CCR_OFF_SADDR) begin
        saddr_q <= reg_wdata[6:0];
      end
      if (reg_addr == `I2CCR_OFF_MASK) begin
        irq_mask_q <= reg_wdata[`I2CCR_IRQ_W-1:0];
      end
    end
  end

  // Start, stop and collision events gated by their enables; master done and slave byte ungated
  wire [`I2CCR_IRQ_W-1:0] ev;
  assign ev[`I2CCR_I_START] = start_det & ctrl_q[`I2CCR_B_START_IRQ]; // [R2]
  assign ev[`I2CCR_I_STOP] = stop_det & ctrl_q[`I2CCR_B_STOP_IRQ]; // [R1]
  assign ev[`I2CCR_I_COLL] = coll_det & ctrl_q[`I2CCR_B_SLV_COLL]; // [R5]
  assign ev[`I2CCR_I_MDONE] = m_last;
  assign ev[`I2CCR_I_SBYTE] = s_accept;

  // Sticky status, write one to clear; events win
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_st_q <= {`I2CCR_IRQ_W{1'b0}};
    end else if (ce) begin
      irq_st_q <= (irq_st_q & ~(wr_irq ? reg_wdata[`I2CCR_IRQ_W-1:0] : {`I2CCR_IRQ_W{1'b0}})) | ev;
    end
  end

  // Receive buffer and flags; set wins over clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxbuf_q <= 8'h00;
      full_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (ce) begin
      if (s_accept) begin
        rxbuf_q <= s_shift_q; // [R3]
      end else if (m_rx_done && !full_q) begin
        rxbuf_q <= m_rx_byte;
      end
      if (s_accept || (m_rx_done && !full_q)) begin
        full_q <= 1'b1;
      end else if (rd_rxb) begin
        full_q <= 1'b0;
      end
      if ((s_take || m_rx_done) && full_q) begin
        ovf_q <= 1'b1;
      end else if (wr_stat && reg_wdata[`I2CCR_S_OVERFLOW]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // Master sequencer, one step per half period
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_state_q <= M_IDLE;
      m_step_q <= 2'h0;
      m_bit_q <= 4'h0;
      m_shift_q <= 8'h00;
      m_scl_q <= 1'b0;
      m_sda_q <= 1'b0;
    end else if (run) begin
      if (!on) begin
        m_state_q <= M_IDLE;
        m_scl_q <= 1'b0;
        m_sda_q <= 1'b0;
      end else if (m_idle) begin
        m_step_q <= 2'h0;
        m_bit_q <= 4'h0;
        // One sequence at a time, start has priority
        if (ctrl_q[`I2CCR_B_START_SEQ]) begin
          m_state_q <= M_START; // [R12]
          m_scl_q <= 1'b0;
          m_sda_q <= 1'b0;
        end else if (ctrl_q[`I2CCR_B_RSTART]) begin
          m_state_q <= M_RSTART;
          m_scl_q <= 1'b1;
          m_sda_q <= 1'b0;
        end else if (ctrl_q[`I2CCR_B_STOP_SEQ]) begin
          m_state_q <= M_STOP;
          m_scl_q <= 1'b1;
          m_sda_q <= 1'b1;
        end else if (ctrl_q[`I2CCR_B_RECV]) begin
          m_state_q <= M_RECV;
          m_scl_q <= 1'b1;
          m_sda_q <= 1'b0;
        end else if (ctrl_q[`I2CCR_B_ACK_SEQ]) begin
          m_state_q <= M_ACK;
          m_scl_q <= 1'b1;
          m_sda_q <= ~ctrl_q[`I2CCR_B_ACK_DATA];
        end
      end else if (m_tick) begin
        m_step_q <= m_step_q + 2'h1;
        case (m_state_q)
          M_START: begin
            if (m_step_q == 2'h0) begin
              m_sda_q <= 1'b1;
            end else begin
              m_scl_q <= 1'b1;
              m_state_q <= M_IDLE;
            end
          end
          M_RSTART: begin
            if (m_step_q == 2'h0) begin
              m_scl_q <= 1'b0;
            end else if (m_step_q == 2'h1) begin
              m_sda_q <= 1'b1;
            end else begin
              m_scl_q <= 1'b1;
              m_state_q <= M_IDLE;
            end
          end
          M_STOP: begin
            if (m_step_q == 2'h0) begin
              m_scl_q <= 1'b0;
            end else begin
              m_sda_q <= 1'b0;
              m_state_q <= M_IDLE;
            end
          end
          M_ACK: begin
            if (m_step_q == 2'h0) begin
              m_scl_q <= 1'b0;
            end else begin
              m_scl_q <= 1'b1;
              m_sda_q <= 1'b0;
              m_state_q <= M_IDLE;
            end
          end
          M_RECV: begin
            if (m_step_q == 2'h0) begin
              m_scl_q <= 1'b0;
            end else begin
              // Sample at end of high phase
              m_scl_q <= 1'b1;
              m_shift_q <= m_rx_byte;
              m_bit_q <= m_bit_q + 4'h1;
              m_step_q <= 2'h0;
              if (m_bit_q == 4'h7) begin
                m_state_q <= M_IDLE;
              end
            end
          end
          default: m_state_q <= M_IDLE;
        endcase
      end
    end
  end

  // Slave receiver: write transfers only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_state_q <= S_IDLE;
      s_shift_q <= 8'h00;
      s_cnt_q <= 4'h0;
      s_first_q <= 1'b0;
      s_want_q <= 1'b0;
    end else if (run) begin
      if (!on || !m_idle) begin
        s_state_q <= S_IDLE;
        s_want_q <= 1'b0;
      end else if (start_det) begin
        s_state_q <= S_BITS;
        s_cnt_q <= 4'h0;
        s_first_q <= 1'b1;
        s_want_q <= 1'b0;
      end else if (stop_det) begin
        s_state_q <= S_IDLE;
        s_want_q <= 1'b0;
      end else begin
        case (s_state_q)
          S_BITS: begin
            if (scl_rise && s_cnt_q != 4'h8) begin
              s_shift_q <= {s_shift_q[6:0], sda_lvl};
              s_cnt_q <= s_cnt_q + 4'h1;
            end else if (s_done) begin
              // Ack only a byte the buffer took
              s_want_q <= s_accept;
              s_state_q <= s_take ? S_ACK : S_SKIP;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              s_want_q <= 1'b0;
              s_cnt_q <= 4'h0;
              s_first_q <= 1'b0;
              s_state_q <= S_BITS;
            end
          end
          S_SKIP: s_want_q <= 1'b0;
          S_IDLE: s_want_q <= 1'b0;
          default: s_state_q <= S_IDLE;
        endcase
      end
    end
  end

  // Data line moves a hold time after a clock fall
  wire [31:0] hold_cyc = ctrl_q[`I2CCR_B_HOLD_TIME] ? HOLD_LONG : HOLD_SHORT; // [R4]
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt_q <= 5'h00;
      s_sda_q <= 1'b0;
    end else if (run) begin
      if (!on) begin
        hold_cnt_q <= 5'h00;
        s_sda_q <= 1'b0;
      end else if (scl_fall) begin
        hold_cnt_q <= hold_cyc[4:0]; // [R4]
      end else if (hold_cnt_q != 5'h00) begin
        hold_cnt_q <= hold_cnt_q - 5'h01;
        if (hold_cnt_q == 5'h01) begin
          s_sda_q <= s_want_q; // [R4]
        end
      end
    end
  end

  // Pin drivers; a cleared clock release stretches the clock
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      scl_oe_q <= on & (m_scl_q | ~ctrl_q[`I2CCR_B_CLK_REL]); // [R8] [R6] [R7]
      sda_oe_q <= on & (m_sda_q | s_sda_q); // [R8]
    end
  end

  // Read data, valid one cycle after strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `I2CCR_OFF_CTRL: rdata_q <= ctrl_q & `I2CCR_CTRL_WMASK; // [R10]
          `I2CCR_OFF_STAT: rdata_q <= {25'h0, ovf_q, 3'h0, full_q, 1'b0, ~m_idle};
          `I2CCR_OFF_IRQ: rdata_q <= {27'h0, irq_st_q};
          `I2CCR_OFF_MASK: rdata_q <= {27'h0, irq_mask_q};
          `I2CCR_OFF_RXB: rdata_q <= {24'h0, rxbuf_q};
          `I2CCR_OFF_SADDR: rdata_q <= {25'h0, saddr_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Open-drain pins only ever drive low
  assign reg_rdata = rdata_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign pins_serial = ctrl_q[`I2CCR_B_ENABLE]; // [R8]
  assign irq = |(irq_st_q & irq_mask_q);
endmodule // i2ccr_top
`default_nettype wire

// >>> tb/i2ccr_peer.sv
// Purpose: far-side bus master model on the shared clock and data lines
// Assumes: open-drain lines with pull-ups
// Notes: low phase is long so the device hold time fits before the rise
`timescale 1ns/10ps
`default_nettype none
module i2ccr_peer (
  // Clock
  input wire logic clk,
  // Device drives
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  // Resolved lines
  output wire logic scl_line,
  output wire logic sda_line
);
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  logic hung = 1'b0;
  int ack_q[$];
  // Pull-ups: high unless a party pulls low
  assign scl_line = !(scl_lo || dev_scl_oe);
  assign sda_line = !(sda_lo || dev_sda_oe);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves while clock low; stretching honoured
  task automatic put_bit(input logic b, output logic s);
    int n;
    n = 0;
    wt(4);
    sda_lo <= !b;
    wt(16);
    scl_lo <= 1'b0;
    while (!scl_line && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n == 5000)
      hung = 1'b1;
    wt(4);
    s = sda_line;
    scl_lo <= 1'b1;
  endtask
  // Byte MSB first, then the ninth bit with data released
  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i], s);
    put_bit(1'b1, s);
    ack_q.push_back(s);
  endtask
  task automatic start();
    wt(4);
    sda_lo <= 1'b0;
    wt(4);
    scl_lo <= 1'b0;
    wt(8);
    sda_lo <= 1'b1;
    wt(8);
    scl_lo <= 1'b1;
  endtask
  task automatic stop();
    wt(4);
    sda_lo <= 1'b1;
    wt(16);
    scl_lo <= 1'b0;
    wt(8);
    sda_lo <= 1'b0;
    wt(8);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    start();
    put_byte(a);
    put_byte(d);
    stop();
  endtask
  // Restart three bits into a byte, then stop
  task automatic clash();
    logic s;
    start();
    repeat (3) put_bit(1'b1, s);
    start();
    stop();
  endtask
endmodule // i2ccr_peer
`default_nettype wire

// >>> tb/i2ccr_sva.sv
// Purpose: port checker for the serial bus control block
// Assumes: one clock domain, bound to i2ccr_top
// Notes: slave timing checks stop once a master sequence is used
`timescale 1ns/10ps
`default_nettype none
`include "i2ccr_map.vh"
module i2ccr_chk #(
  parameter [7:0] HALF_PERIOD = 8'd125
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [`I2CCR_AW-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Pins, idle and interrupt
  input wire idle_mode,
  input wire scl_in,
  input wire scl_oe,
  input wire sda_oe,
  input wire pins_serial,
  input wire irq
);
  localparam int MST_WAIT = 3 * HALF_PERIOD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Control writes seen at the port
  wire ctl_wr = reg_wr && reg_addr == `I2CCR_OFF_CTRL;
  wire rel_wr = ctl_wr && reg_wdata[12];
  reg hsel_q;
  reg stop_in_idle_q;
  reg mst_q;
  reg [7:0] lo_q;
  // Config shadow, clock-low age, master use
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hsel_q <= 1'b0;
      stop_in_idle_q <= 1'b0;
      mst_q <= 1'b0;
      lo_q <= 8'h00;
    end else begin
      if (ctl_wr) begin
        hsel_q <= reg_wdata[19];
        stop_in_idle_q <= reg_wdata[13];
      end
      if (ctl_wr && |reg_wdata[4:0])
        mst_q <= 1'b1;
      if (scl_in)
        lo_q <= 8'h00;
      else if (lo_q != 8'hff)
        lo_q <= lo_q + 8'h01;
    end
  end
  sequence idle_run;
    (stop_in_idle_q && idle_mode && !reg_wr) [*3];
  endsequence
  sequence mst_go;
    ctl_wr && reg_wdata[15] && reg_wdata[4:0] == 5'h01;
  endsequence
  rd_unused_a: assert property ($past(reg_rd) && $past(reg_addr) == 6'h00
    |-> reg_rdata[31:23] == 9'h000 && !reg_rdata[14]) else $error("reserved control bits read nonzero");
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  pin_own_a: assert property (ctl_wr |=> pins_serial == $past(reg_wdata[15]))
    else $error("pin ownership not from enable bit");
  pin_free_a: assert property (!pins_serial |-> !scl_oe && !sda_oe)
    else $error("pins driven while disabled");
  hold_time_a: assert property (!mst_q && !scl_in && $changed(sda_oe)
    |-> lo_q >= (hsel_q ? 8'd15 : 8'd5)) else $error("data changed inside hold time");
  hold_clk_a: assert property (!mst_q && $rose(scl_oe) |-> !$past(scl_in, 2))
    else $error("clock hold not after a falling edge");
  keep_clk_a: assert property (!mst_q && scl_oe && !rel_wr && !$past(rel_wr) |=> scl_oe)
    else $error("clock hold dropped without release");
  idle_halt_a: assert property (idle_run |-> $stable(scl_oe) && $stable(sda_oe) && $stable(irq))
    else $error("activity while halted in idle");
  mst_start_a: assert property (mst_go |-> ##[1:MST_WAIT] sda_oe ##[1:MST_WAIT] scl_oe)
    else $error("start sequence late");
endmodule // i2ccr_chk
bind i2ccr_top i2ccr_chk #(.HALF_PERIOD(HALF_PERIOD)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
  .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .pins_serial(pins_serial), .irq(irq));
`default_nettype wire

// >>> tb/i2ccr_top_test.sv
// Purpose: self-checking bench for the serial bus control block
// Assumes: far-side master model, HALF_PERIOD cut to 4
// Notes: expectations come from the register rules
`timescale 1ns/10ps
`default_nettype none
module i2ccr_top_test;
  localparam int EN = 1 << 15;
  localparam int REL = 1 << 12;
  localparam int SPI = 1 << 22;
  localparam int STI = 1 << 21;
  localparam int COL = 1 << 18;
  localparam int HT = 1 << 19;
  localparam int HLD = 3 << 16;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic idle_mode = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic scl_oe, sda_oe, scl_in, sda_in, pins_serial, irq;
  int miscompares = 0;
  int check_count = 0;
  int cfg;
  int d;
  int seq[5] = '{0, 1, 3, 4, 2};
  logic [31:0] v;
  always #10 clk = ~clk;
  i2ccr_top #(.HALF_PERIOD(8'h04)) i_i2ccr_top (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .idle_mode(idle_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(),
    .sda_oe(sda_oe), .pins_serial(pins_serial), .irq(irq));
  i2ccr_peer peer (.clk(clk), .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands one cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    rd(a, x);
    chk(nm, e, x);
  endtask
  task automatic give_up(input int n);
    if (n >= 4000) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic wait_oe(input logic val);
    int n;
    n = 0;
    while (scl_oe !== val && n < 4000) begin
      @(negedge clk);
      n++;
    end
    give_up(n);
  endtask
  task automatic poll_clear(input int b);
    logic [31:0] x;
    int n;
    n = 0;
    x = 32'h1 << b;
    while (x[b] !== 1'b0 && n < 4000) begin
      rd(6'h00, x);
      n++;
    end
    give_up(n);
  endtask
  initial begin
    void'($urandom(8));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rc("ctrl", 6'h00, REL);
    rc("hole", 6'h3c, 32'h0);
    wr(6'h00, 32'hffff_ffe0);
    rc("ctrl", 6'h00, 32'hffff_ffe0 & ~32'hff80_4000);
    chk("pins", 1, pins_serial);
    wr(6'h00, 0);
    rc("pins_off", 6'h00, 0);
    chk("pins", 0, pins_serial);
    wr(6'h0c, 32'h1f);
    $display("test registers done");
    cfg = EN | REL | SPI | STI | HT | HLD;
    wr(6'h00, cfg);
    d = $urandom & 8'hff;
    fork
      peer.frame(8'h54, d[7:0]);
      for (int k = 0; k < 2; k++) begin
        wait_oe(1'b1);
        rc("ctrl", 6'h00, cfg & ~REL);
        rc("rxb", 6'h10, k ? d : 32'h54);
        wr(6'h00, cfg);
        wait_oe(1'b0);
      end
    join
    chk("ack", 0, peer.ack_q.pop_front());
    chk("ack", 0, peer.ack_q.pop_front());
    rc("irq", 6'h08, 32'h13);
    chk("irq_pin", 1, irq);
    wr(6'h0c, 0);
    @(negedge clk);
    chk("irq_masked", 0, irq);
    wr(6'h0c, 32'h1f);
    wr(6'h08, 32'h1f);
    rc("irq", 6'h08, 0);
    chk("irq_pin", 0, irq);
    $display("test hold done");
    for (int b = 0; b < 2; b++) begin
      wr(6'h00, EN | REL | (b << 20));
      peer.frame(8'h54, $urandom & 8'hff);
      rc("stat", 6'h04, 32'h44);
      rc("rxb", 6'h10, 32'h54);
      peer.frame(8'h54, 8'h00);
      chk("ack", 0, peer.ack_q.pop_front());
      chk("ack", 1, peer.ack_q.pop_front());
      chk("ack", b ? 0 : 1, peer.ack_q.pop_front());
      chk("ack", 1, peer.ack_q.pop_front());
      rd(6'h10, v);
      wr(6'h04, 32'h40);
      rc("stat", 6'h04, 0);
      wr(6'h08, 32'h1f);
    end
    $display("test overwrite done");
    for (int e = 0; e < 2; e++) begin
      wr(6'h00, EN | REL | (e ? SPI | STI | COL : 0));
      peer.clash();
      rc("irq", 6'h08, e ? 32'h07 : 32'h00);
      wr(6'h08, 32'h1f);
    end
    $display("test events done");
    for (int s = 0; s < 2; s++) begin
      wr(6'h00, EN | REL | STI | (s << 13));
      @(posedge clk);
      idle_mode <= 1'b1;
      peer.start();
      peer.stop();
      @(posedge clk);
      idle_mode <= 1'b0;
      rc("irq", 6'h08, s ? 0 : 1);
      wr(6'h08, 32'h1f);
    end
    $display("test idle done");
    foreach (seq[i]) begin
      wr(6'h00, EN | REL | (1 << seq[i]));
      poll_clear(seq[i]);
      rc("irq", 6'h08, 32'h08);
      wr(6'h08, 32'h1f);
    end
    rc("rxb", 6'h10, 32'hff);
    chk("peer_stall", 0, peer.hung);
    $display("test master done");
    report_and_stop();
  end
endmodule // i2ccr_top_test
`default_nettype wire
